// *** src/cmp_consts.svh ***
/*
 * register offsets, field positions, reset values and timing counts for the
 * comparator control block. assumes an 8-bit special-function register port.
 */
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_ADDR_INSEL      8'h9f
`define CMP_ADDR_CTRL       8'hf8
`define CMP_RST_INSEL       8'h00
`define CMP_RST_CTRL        8'h00
`define CMP_BIT_ENABLE      7
`define CMP_BIT_OUTSTATE    6
`define CMP_BIT_RISEFLAG    5
`define CMP_BIT_FALLFLAG    4
`define CMP_HYSP_HI         3
`define CMP_HYSP_LO         2
`define CMP_HYSN_HI         1
`define CMP_HYSN_LO         0
`define CMP_NSEL_HI         5
`define CMP_NSEL_LO         4
`define CMP_PSEL_HI         1
`define CMP_PSEL_LO         0
`define CMP_INSEL_MASK      8'h33
`define CMP_SYNC_STAGES     2

`endif

// *** src/cmp_pkg.sv ***
/*
 * types shared by the comparator control files.
 * assumes cmp_consts.svh supplies the numbers.
 */
package cmp_pkg;
    // hysteresis amount codes, same for both directions
    typedef enum logic [1:0] {
        HYS_OFF  = 2'b00,
        HYS_5MV  = 2'b01,
        HYS_10MV = 2'b10,
        HYS_20MV = 2'b11
    } cmp_hys_t;

    // edge detector state
    typedef struct packed {
        logic [1:0] syncQ;
        logic       levelQ;
        logic       primedQ;
        logic       riseQ;
        logic       fallQ;
    } cmp_edge_st_t;
endpackage

// *** src/cmp_edge_if.sv ***
/*
 * carries the synchronised comparator level and edge pulses between the
 * edge detector and the register block. single clock domain.
 */
`timescale 1ns/1ps
interface cmp_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// *** src/cmp_edge_det.sv ***
/*
 * two-flop synchroniser and edge detector for the raw comparator output.
 * assumes ref_clk domain; rawIn is asynchronous.
 */
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_edge_det (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clkEn,
    input  wire logic enable,
    input  wire logic rawIn,
    cmp_edge_if.src   edges
);
    cmp_pkg::cmp_edge_st_t st_q;
    cmp_pkg::cmp_edge_st_t st_d;

    initial begin
        if (`CMP_SYNC_STAGES != 2) $error("two sync stages expected");
    end

    // first stage feeds only the second; edges compare second stage to last
    always_comb begin
        st_d = st_q;
        st_d.syncQ = {st_q.syncQ[0], rawIn};
        st_d.levelQ = st_q.syncQ[1];
        st_d.primedQ = enable;
        // a disabled comparator is not watched, so no edges on enable
        st_d.riseQ = enable && st_q.primedQ && st_q.syncQ[1] && !st_q.levelQ;
        st_d.fallQ = enable && st_q.primedQ && !st_q.syncQ[1] && st_q.levelQ;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    assign edges.level = st_q.levelQ;
    assign edges.rise  = st_q.riseQ;
    assign edges.fall  = st_q.fallQ;
endmodule

// *** src/cmp_mux_dec.sv ***
/*
 * decodes the input-select fields into one-hot pin selects for the analog
 * multiplexers. purely combinational; the top registers its result.
 */
`timescale 1ns/1ps
module cmp_mux_dec (
    input  wire logic [1:0] posSel,
    input  wire logic [1:0] negSel,
    output logic      [3:0] posPins,
    output logic      [3:0] negPins
);
    // bit k of posPins is P0.(2k), of negPins is P0.(2k+1)
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_pin
            assign posPins[k] = (posSel == 2'(k));
            assign negPins[k] = (negSel == 2'(k));
        end
    endgenerate
endmodule

// *** src/comparator_control_logic.sv ***
/*
 * control and status registers around an analog voltage comparator.
 * assumes an 8-bit special-function register port on ref_clk, and an analog
 * core whose raw output is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "cmp_consts.svh"
module comparator_control_logic (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       clkEn,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWr,
    input  wire logic       sfrRd,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    input  wire logic       cmpRaw,
    output logic            cmpEnable,
    output logic      [1:0] posHysteresis,
    output logic      [1:0] negHysteresis,
    output logic      [3:0] posPinSel,
    output logic      [3:0] negPinSel,
    output logic            cmpPinOut,
    output logic            riseIrq,
    output logic            fallIrq
);
    // all state of this module in one struct
    typedef struct packed {
        logic       enQ;
        logic       riseFlagQ;
        logic       fallFlagQ;
        logic [1:0] hysPQ;
        logic [1:0] hysNQ;
        logic [1:0] nSelQ;
        logic [1:0] pSelQ;
        logic [7:0] rdataQ;
        logic [3:0] posPinQ;
        logic [3:0] negPinQ;
        logic       pinOutQ;
        logic       riseIrqQ;
        logic       fallIrqQ;
    } cmp_top_st_t;

    cmp_top_st_t st_q;
    cmp_top_st_t st_d;

    cmp_edge_if edges ();
    logic [3:0] posPinsDec;
    logic [3:0] negPinsDec;
    logic       wrCtrl;
    logic       wrInsel;
    logic [7:0] ctrlView;
    logic [7:0] inselView;

    // edge detection runs off the synchronised level only
    cmp_edge_det u_edge (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .enable  (st_q.enQ),
        .rawIn   (cmpRaw),
        .edges   (edges)
    );

    cmp_mux_dec u_mux (
        .posSel  (st_q.pSelQ),
        .negSel  (st_q.nSelQ),
        .posPins (posPinsDec),
        .negPins (negPinsDec)
    );

    assign wrCtrl  = sfrWr && (sfrAddr == `CMP_ADDR_CTRL);
    assign wrInsel = sfrWr && (sfrAddr == `CMP_ADDR_INSEL);

    // readback images; the analog core decides polarity, high means pos > neg
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[`CMP_BIT_ENABLE]   = st_q.enQ;
        ctrlView[`CMP_BIT_OUTSTATE] = edges.level;
        ctrlView[`CMP_BIT_RISEFLAG] = st_q.riseFlagQ;
        ctrlView[`CMP_BIT_FALLFLAG] = st_q.fallFlagQ;
        ctrlView[`CMP_HYSP_HI:`CMP_HYSP_LO] = st_q.hysPQ;
        ctrlView[`CMP_HYSN_HI:`CMP_HYSN_LO] = st_q.hysNQ;
        inselView = 8'h00;
        inselView[`CMP_NSEL_HI:`CMP_NSEL_LO] = st_q.nSelQ;
        inselView[`CMP_PSEL_HI:`CMP_PSEL_LO] = st_q.pSelQ;
    end

    // next state: writes, flag sets, registered outputs
    always_comb begin
        st_d = st_q;
        if (wrCtrl) begin
            st_d.enQ   = sfrWdata[`CMP_BIT_ENABLE];
            st_d.hysPQ = sfrWdata[`CMP_HYSP_HI:`CMP_HYSP_LO];
            st_d.hysNQ = sfrWdata[`CMP_HYSN_HI:`CMP_HYSN_LO];
            // software may write either flag; writing one also sets it
            st_d.riseFlagQ = sfrWdata[`CMP_BIT_RISEFLAG];
            st_d.fallFlagQ = sfrWdata[`CMP_BIT_FALLFLAG];
        end
        if (wrInsel) begin
            st_d.nSelQ = sfrWdata[`CMP_NSEL_HI:`CMP_NSEL_LO];
            st_d.pSelQ = sfrWdata[`CMP_PSEL_HI:`CMP_PSEL_LO];
        end
        // a set in the same cycle as a clear wins, so no edge is lost
        if (edges.rise) begin
            st_d.riseFlagQ = 1'b1;
        end
        if (edges.fall) begin
            st_d.fallFlagQ = 1'b1;
        end
        // read data registered one cycle after the strobe; 0 when unmapped
        if (sfrRd) begin
            case (sfrAddr)
                `CMP_ADDR_CTRL: begin
                    st_d.rdataQ = ctrlView;
                end
                `CMP_ADDR_INSEL: begin
                    st_d.rdataQ = inselView;
                end
                default: begin
                    st_d.rdataQ = 8'h00;
                end
            endcase
        end
        st_d.posPinQ  = posPinsDec;
        st_d.negPinQ  = negPinsDec;
        st_d.pinOutQ  = st_q.enQ & edges.level;
        st_d.riseIrqQ = edges.rise;
        st_d.fallIrqQ = edges.fall;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.posPinQ <= 4'h1;   // code 00 selects the first pin
            st_q.negPinQ <= 4'h1;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign sfrRdata      = st_q.rdataQ;
    assign cmpEnable     = st_q.enQ;
    assign posHysteresis = st_q.hysPQ;
    assign negHysteresis = st_q.hysNQ;
    assign posPinSel     = st_q.posPinQ;
    assign negPinSel     = st_q.negPinQ;
    assign cmpPinOut     = st_q.pinOutQ;
    assign riseIrq       = st_q.riseIrqQ;
    assign fallIrq       = st_q.fallIrqQ;
endmodule

// *** sim/cmp_ctl_sva.sv ***
/* assertions on the ports of the comparator control top, bound to it.
   assumes clkEn stays high and cmpRaw holds each level for 8 cycles or more. */
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_ctl_sva (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWr,
    input wire logic [7:0] sfrWdata,
    input wire logic       cmpRaw,
    input wire logic       cmpEnable,
    input wire logic [1:0] posHysteresis,
    input wire logic [1:0] negHysteresis,
    input wire logic [3:0] posPinSel,
    input wire logic [3:0] negPinSel,
    input wire logic       cmpPinOut,
    input wire logic       riseIrq,
    input wire logic       fallIrq
);
    logic wC;
    logic wM;
    // decoded write strokes, so each property reads plainly
    assign wC = sfrWr && sfrAddr == `CMP_ADDR_CTRL;
    assign wM = sfrWr && sfrAddr == `CMP_ADDR_INSEL;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    chk_ctl_write: assert property (wC |=>
        {cmpEnable, 3'h0, posHysteresis, negHysteresis} == ($past(sfrWdata) & 8'h8f))
        else $error("control fields not taken from write");
    chk_mux_write: assert property (wM |=> ##1
        {posPinSel, negPinSel} ==
        {4'h1 << $past(sfrWdata[1:0], 2), 4'h1 << $past(sfrWdata[5:4], 2)})
        else $error("pin select not decoded from write");
    chk_pin_off: assert property (!cmpEnable [*2] |-> !cmpPinOut)
        else $error("pin output high while disabled");
    chk_rise_src: assert property (riseIrq |-> $past(cmpRaw, 3) && !$past(cmpRaw, 7))
        else $error("rise pulse without rising input");
    chk_fall_src: assert property (fallIrq |-> !$past(cmpRaw, 3) && $past(cmpRaw, 7))
        else $error("fall pulse without falling input");
    chk_rise_due: assert property (
        $rose(cmpRaw) && cmpEnable && $past(cmpEnable, 2) |-> ##[2:6] riseIrq)
        else $error("rising edge missed");
    chk_fall_due: assert property (
        $fell(cmpRaw) && cmpEnable && $past(cmpEnable, 2) |-> ##[2:6] fallIrq)
        else $error("falling edge missed");
    chk_irq_pulse: assert property (riseIrq || fallIrq |=> !riseIrq && !fallIrq)
        else $error("edge pulse longer than one clock");
    cov_rise: cover property (riseIrq);
    cov_fall: cover property (fallIrq);
    cov_enable: cover property (wC && sfrWdata[7]);
endmodule
bind comparator_control_logic cmp_ctl_sva i_cmp_ctl_sva (.*);

// *** sim/cmp_analog_mdl.sv ***
/* behavioural analog comparator with its two input multiplexers.
   assumes eight pin voltages packed 8 bits each, pin 0 lowest. */
`timescale 1ns/1ps
module cmp_analog_mdl (
    input wire logic [63:0] pinMv,
    input wire logic [3:0]  posPinSel,
    input wire logic [3:0]  negPinSel,
    output logic            cmpRaw
);
    logic [7:0] vPos;
    logic [7:0] vNeg;
    // even pins feed the plus side, odd pins the minus side
    always_comb begin
        vPos = 8'h00;
        vNeg = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (posPinSel[k]) vPos = pinMv[16*k +: 8];
            if (negPinSel[k]) vNeg = pinMv[16*k+8 +: 8];
        end
        // no hysteresis modelled, so near-equal inputs switch sharply
        cmpRaw = vPos > vNeg;
    end
endmodule

// *** sim/tb.sv ***
/* self-checking bench for the comparator control top.
   assumes the analog model closes the loop from pin selects to cmpRaw. */
`timescale 1ns/1ps
`include "cmp_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module tb;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        sfrWr = 1'b0;
    logic        sfrRd = 1'b0;
    logic [7:0]  sfrAddr = 8'h00;
    logic [7:0]  sfrWdata = 8'h00;
    logic [7:0]  sfrRdata, ctl, sel;
    logic [63:0] pinMv = 64'h0;
    logic [3:0]  posPinSel, negPinSel;
    logic [1:0]  posHysteresis, negHysteresis;
    logic        cmpRaw, cmpEnable, cmpPinOut, riseIrq, fallIrq, lvl, nl;
    int          fails = 0, checks_done = 0, rc = 0, fc = 0, erc = 0, efc = 0;

    // 20 MHz system clock
    always #25 ref_clk = ~ref_clk;
    // tally edge pulses; compared with the bench's own edge count at the end
    always @(posedge ref_clk) begin
        if (riseIrq === 1'b1) rc <= rc + 1;
        if (fallIrq === 1'b1) fc <= fc + 1;
    end

    comparator_control_logic i_comparator_control_logic (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
        .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .cmpRaw(cmpRaw),
        .cmpEnable(cmpEnable), .posHysteresis(posHysteresis), .negHysteresis(negHysteresis),
        .posPinSel(posPinSel), .negPinSel(negPinSel), .cmpPinOut(cmpPinOut),
        .riseIrq(riseIrq), .fallIrq(fallIrq));
    cmp_analog_mdl i_cmp_analog_mdl (.pinMv(pinMv), .posPinSel(posPinSel),
        .negPinSel(negPinSel), .cmpRaw(cmpRaw));

    // expected level: equal inputs read as zero
    function automatic logic lvlOf(logic [63:0] v, logic [7:0] s);
        return v[16*s[1:0] +: 8] > v[16*s[5:4]+8 +: 8];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWr <= 1'b1;
        @(posedge ref_clk);
        sfrWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(posedge ref_clk);
        sfrRd <= 1'b0;
        #1 `CHK(sfrRdata, e)
    endtask
    // let the sync chain settle, then book any edge seen while enabled
    task automatic settle();
        repeat (10) @(posedge ref_clk);
        nl = lvlOf(pinMv, sel);
        if (ctl[7] && nl != lvl) begin
            ctl[5:4] |= {nl, !nl};
            erc += int'(nl);
            efc += int'(!nl);
        end
        lvl = nl;
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(69));
        ctl = 8'h00;
        sel = 8'h00;
        lvl = 1'b0;
        repeat (12) @(posedge ref_clk);
        `CHK({posPinSel, negPinSel, cmpPinOut}, 9'h022)
        rstn <= 1'b1;
        rd(`CMP_ADDR_CTRL, 8'h00);
        rd(`CMP_ADDR_INSEL, 8'h00);
        // unmapped place: write ignored, read gives zero
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        rd(`CMP_ADDR_CTRL, 8'h00);
        // random selects, pins and control values; low nibble walks all codes
        for (int i = 0; i < 40; i++) begin
            sel = 8'($urandom);
            wr(`CMP_ADDR_INSEL, sel);
            // pin selects are decoded from the stored field, so they lag the write by a cycle
            rd(`CMP_ADDR_INSEL, sel & `CMP_INSEL_MASK);
            `CHK({posPinSel, negPinSel}, {4'h1 << sel[1:0], 4'h1 << sel[5:4]})
            settle();
            ctl = {4'($urandom), 4'(i)};
            wr(`CMP_ADDR_CTRL, ctl);
            `CHK({cmpEnable, posHysteresis, negHysteresis}, {ctl[7], ctl[3:0]})
            settle();
            pinMv <= {$urandom, $urandom};
            settle();
            rd(`CMP_ADDR_CTRL, {ctl[7], lvl, ctl[5:0]});
            `CHK(cmpPinOut, ctl[7] & lvl)
        end
        `CHK({rc, fc}, {erc, efc})
        test_done();
    end
endmodule
